// [timer_defines.vh]
// register map, field positions and reset values of the timer block
`ifndef TIMER_DEFINES_VH
`define TIMER_DEFINES_VH

// register indexes; avalon word address equals the index
`define IDX_MASTER_ACTION 6'h08
`define IDX_COUNT 6'h0a
`define IDX_ACCUM 6'h0c
`define IDX_CAPTURE_1 6'h0e
`define IDX_CAPTURE_2 6'h10
`define IDX_CAPTURE_3 6'h12
`define IDX_MATCH_1 6'h14
`define IDX_MATCH_2 6'h16
`define IDX_MATCH_3 6'h18
`define IDX_MATCH_4 6'h1a
`define IDX_SHARED 6'h1c
`define IDX_ACTION_EDGE 6'h1e
`define IDX_IRQ_ENABLE 6'h20
`define IDX_FLAGS 6'h22

// reset values
`define VALUE_RESET 16'hffff
`define ZERO_RESET 16'h0000

// accumulator setup byte (bits 15:8 of the accumulator word)
`define SETUP_ON 6
`define SETUP_GATED 5
`define SETUP_POL 4
`define SETUP_ROLE 2
`define SETUP_WMASK 8'h77

// timer clock select value that picks the external clock pin
`define CLK_SEL_EXT 3'h7
// prescaler value giving the system clock divided by 512
`define PRESC_LAST 9'h1ff

// flag and enable word; bit 6 and bits 3:0 of flags read as zero
`define FLAG_MASK 16'hffb0
`define EN_CLK_OUT 3
`endif

// [timer_capture_compare_accumulator.v]
// timer core: free-running count, capture, compare, pulse accumulator
`timescale 1ns/100ps
`default_nettype none

`include "timer_defines.vh"

module timer_capture_compare_accumulator (
  input wire clk,
  input wire rst_n,
  input wire [5:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output wire avs_waitrequest,
  input wire [3:1] capture_pin,
  input wire ch5_pin_in,
  input wire accum_input_pin,
  input wire ext_clk_pin,
  output wire [5:1] match_pin_out,
  output wire [5:1] match_pin_oe,
  output reg timer_irq
);

  // ==========================================================
  // functions
  function tap_hit;
    input [8:0] p;
    input [2:0] s;
    begin
      case (s)
        3'h0: tap_hit = p[0];
        3'h1: tap_hit = &p[1:0];
        3'h2: tap_hit = &p[2:0];
        3'h3: tap_hit = &p[3:0];
        3'h4: tap_hit = &p[4:0];
        3'h5: tap_hit = &p[5:0];
        3'h6: tap_hit = &p[6:0];
        default: tap_hit = 1'b0;
      endcase
    end
  endfunction

  function edge_hit;
    input rise;
    input fall;
    input [1:0] sel;
    begin
      case (sel)
        2'h1: edge_hit = rise;
        2'h2: edge_hit = fall;
        2'h3: edge_hit = rise | fall;
        default: edge_hit = 1'b0;
      endcase
    end
  endfunction

  function [15:0] merge;
    input [15:0] old;
    input [15:0] wd;
    input [1:0] be;
    begin
      merge = old;
      if (be[1]) begin
        merge[15:8] = wd[15:8];
      end
      if (be[0]) begin
        merge[7:0] = wd[7:0];
      end
    end
  endfunction

  // ==========================================================
  // state
  reg ack_r;
  reg [5:1] mask_r;
  reg [5:1] levels_r;
  reg [15:0] count_r;
  reg [7:0] setup_r;
  reg [7:0] acc_r;
  reg [15:0] cap_r [1:3];
  reg [15:0] match_r [1:4];
  reg [15:0] shared_r;
  reg [15:0] ctl_r;
  reg [15:0] en_r;
  reg [15:0] flag_r;
  reg [8:0] presc_r;
  reg adv_r;
  reg clk_out_r;
  reg [5:1] pin_r;
  reg [5:0] in_s1_r;
  reg [5:0] in_s2_r;
  reg [5:0] in_s3_r;
  reg [5:1] pin_nxt;
  reg [15:0] rd_nxt;
  integer i;
  integer j;

  // ==========================================================
  // avalon handshake: one wait state for every access
  wire [15:0] wd = avs_writedata[15:0];
  wire [1:0] be = avs_byteenable[1:0];
  wire wr = avs_write & ack_r;
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;

  // ==========================================================
  // pin synchronisers and edges
  wire [5:0] rise = in_s2_r & ~in_s3_r;
  wire [5:0] fall = ~in_s2_r & in_s3_r;
  wire acc_level = in_s2_r[4];
  wire ext_level = in_s2_r[5];

  // ==========================================================
  // decoded controls
  wire acc_on = setup_r[`SETUP_ON];
  wire acc_gated = setup_r[`SETUP_GATED];
  wire acc_pol = setup_r[`SETUP_POL];
  wire ch5_role_sel = setup_r[`SETUP_ROLE];
  wire [1:0] gated_clk_sel = setup_r[1:0];
  wire timer_clk_out_en = en_r[`EN_CLK_OUT];
  wire [2:0] timer_clk_sel = en_r[2:0];

  // timer clock from prescaler tap or external pin
  wire timer_tick = (timer_clk_sel == `CLK_SEL_EXT) ? rise[5] :
    tap_hit(presc_r, timer_clk_sel);
  wire wrap_evt = timer_tick & (count_r == `VALUE_RESET);

  // compare matches, checked once per count value
  wire [5:1] mev;
  assign mev[1] = adv_r & (count_r == match_r[1]);
  assign mev[2] = adv_r & (count_r == match_r[2]);
  assign mev[3] = adv_r & (count_r == match_r[3]);
  assign mev[4] = adv_r & (count_r == match_r[4]);
  assign mev[5] = adv_r & ~ch5_role_sel & (count_r == shared_r);

  // capture edges
  wire [4:1] cev;
  assign cev[1] = edge_hit(rise[0], fall[0], ctl_r[1:0]);
  assign cev[2] = edge_hit(rise[1], fall[1], ctl_r[3:2]);
  assign cev[3] = edge_hit(rise[2], fall[2], ctl_r[5:4]);
  assign cev[4] = ch5_role_sel & edge_hit(rise[3], fall[3], ctl_r[7:6]);

  // ==========================================================
  // accumulator
  reg acc_src;
  always @* begin
    case (gated_clk_sel)
      2'h0: acc_src = (presc_r == `PRESC_LAST);
      2'h1: acc_src = timer_tick;
      2'h2: acc_src = wrap_evt;
      default: acc_src = rise[5];
    endcase
  end
  // pol 0: falling edge counts, or low inhibits and falling ends period
  wire acc_edge = acc_pol ? rise[4] : fall[4];
  wire acc_gate = acc_level ^ acc_pol;
  wire acc_inc = acc_on &
    (acc_gated ? (acc_gate & acc_src) : acc_edge);
  wire acc_wrap_evt = acc_inc & (acc_r == 8'hff);
  wire acc_in_evt = acc_on & acc_edge;

  // ==========================================================
  // flags and interrupt
  wire [15:0] fset = {cev[4] | mev[5], mev[4:1], cev[3:1], wrap_evt,
    1'b0, acc_wrap_evt, acc_in_evt, 4'h0};
  wire [15:0] fclr = (wr && avs_address == `IDX_FLAGS) ?
    merge(16'h0000, wd, be) : 16'h0000;

  // ==========================================================
  // compare pin actions; master match applied last so it wins
  always @* begin
    pin_nxt = pin_r;
    for (j = 2; j <= 5; j = j + 1) begin
      if (mev[j]) begin
        case (ctl_r[2*j+5 -: 2])
          2'h1: pin_nxt[j] = ~pin_r[j];
          2'h2: pin_nxt[j] = 1'b0;
          2'h3: pin_nxt[j] = 1'b1;
          default: pin_nxt[j] = pin_r[j];
        endcase
      end
    end
    if (mev[1]) begin
      for (j = 1; j <= 5; j = j + 1) begin
        if (mask_r[j]) begin
          pin_nxt[j] = levels_r[j];
        end
      end
    end
  end

  assign match_pin_out[1] = timer_clk_out_en ? clk_out_r : pin_r[1];
  assign match_pin_out[5:2] = pin_r[5:2];
  assign match_pin_oe[1] = 1'b1;
  assign match_pin_oe[2] = (ctl_r[9:8] != 2'h0) | mask_r[2];
  assign match_pin_oe[3] = (ctl_r[11:10] != 2'h0) | mask_r[3];
  assign match_pin_oe[4] = (ctl_r[13:12] != 2'h0) | mask_r[4];
  assign match_pin_oe[5] = ~ch5_role_sel &
    ((ctl_r[15:14] != 2'h0) | mask_r[5]);

  // ==========================================================
  // read mux
  always @* begin
    case (avs_address)
      `IDX_MASTER_ACTION: rd_nxt = {mask_r, 3'h0, levels_r, 3'h0};
      `IDX_COUNT: rd_nxt = count_r;
      `IDX_ACCUM: rd_nxt = {acc_level, setup_r[6:4], ext_level,
        setup_r[2:0], acc_r};
      `IDX_CAPTURE_1: rd_nxt = cap_r[1];
      `IDX_CAPTURE_2: rd_nxt = cap_r[2];
      `IDX_CAPTURE_3: rd_nxt = cap_r[3];
      `IDX_MATCH_1: rd_nxt = match_r[1];
      `IDX_MATCH_2: rd_nxt = match_r[2];
      `IDX_MATCH_3: rd_nxt = match_r[3];
      `IDX_MATCH_4: rd_nxt = match_r[4];
      `IDX_SHARED: rd_nxt = shared_r;
      `IDX_ACTION_EDGE: rd_nxt = ctl_r;
      `IDX_IRQ_ENABLE: rd_nxt = en_r;
      `IDX_FLAGS: rd_nxt = flag_r;
      default: rd_nxt = 16'h0000;
    endcase
  end

  // ==========================================================
  // bus slave and pin sampling
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_r <= 1'b0;
      avs_readdata <= 32'h00000000;
      in_s1_r <= 6'h00;
      in_s2_r <= 6'h00;
      in_s3_r <= 6'h00;
    end else begin
      ack_r <= (avs_read | avs_write) & ~ack_r;
      if (avs_read & ~ack_r) begin
        avs_readdata <= {16'h0000, rd_nxt};
      end
      // first stage feeds only the second
      in_s1_r <= {ext_clk_pin, accum_input_pin, ch5_pin_in, capture_pin};
      in_s2_r <= in_s1_r;
      in_s3_r <= in_s2_r;
    end
  end

  // ==========================================================
  // time base, compare, capture
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      presc_r <= 9'h000;
      count_r <= `ZERO_RESET;
      adv_r <= 1'b0;
      clk_out_r <= 1'b0;
      pin_r <= 5'h00;
      shared_r <= `VALUE_RESET;
      for (i = 1; i <= 3; i = i + 1) begin
        cap_r[i] <= `VALUE_RESET;
      end
      for (i = 1; i <= 4; i = i + 1) begin
        match_r[i] <= `VALUE_RESET;
      end
    end else begin
      presc_r <= presc_r + 9'h001;
      adv_r <= timer_tick;
      if (timer_tick) begin
        count_r <= count_r + 16'h0001;
        clk_out_r <= ~clk_out_r;
      end
      pin_r <= pin_nxt;
      for (i = 1; i <= 3; i = i + 1) begin
        if (cev[i]) begin
          cap_r[i] <= count_r;
        end
      end
      if (cev[4]) begin
        shared_r <= count_r;
      end else if (wr && avs_address == `IDX_SHARED && !ch5_role_sel) begin
        shared_r <= merge(shared_r, wd, be);
      end
      if (wr) begin
        case (avs_address)
          `IDX_MATCH_1: match_r[1] <= merge(match_r[1], wd, be);
          `IDX_MATCH_2: match_r[2] <= merge(match_r[2], wd, be);
          `IDX_MATCH_3: match_r[3] <= merge(match_r[3], wd, be);
          `IDX_MATCH_4: match_r[4] <= merge(match_r[4], wd, be);
          default: begin
          end
        endcase
      end
    end
  end

  // ==========================================================
  // control registers, accumulator, flags
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mask_r <= 5'h00;
      levels_r <= 5'h00;
      setup_r <= 8'h00;
      acc_r <= 8'h00;
      ctl_r <= `ZERO_RESET;
      en_r <= `ZERO_RESET;
      flag_r <= `ZERO_RESET;
      timer_irq <= 1'b0;
    end else begin
      // a hardware set in the clearing cycle survives
      flag_r <= ((flag_r & ~fclr) | fset) & `FLAG_MASK;
      timer_irq <= |(flag_r & en_r & `FLAG_MASK);
      // a software write to the count wins over an increment
      if (wr && avs_address == `IDX_ACCUM && be[0]) begin
        acc_r <= wd[7:0];
      end else if (acc_inc) begin
        acc_r <= acc_r + 8'h01;
      end
      if (wr) begin
        case (avs_address)
          `IDX_MASTER_ACTION: begin
            if (be[1]) begin
              mask_r <= wd[15:11];
            end
            if (be[0]) begin
              levels_r <= wd[7:3];
            end
          end
          `IDX_ACCUM: begin
            if (be[1]) begin
              // pin level bits are not stored
              setup_r <= wd[15:8] & `SETUP_WMASK;
            end
          end
          `IDX_ACTION_EDGE: ctl_r <= merge(ctl_r, wd, be);
          `IDX_IRQ_ENABLE: en_r <= merge(en_r, wd, be) & 16'hffbf;
          default: begin
          end
        endcase
      end
    end
  end

endmodule // timer_capture_compare_accumulator
`default_nettype wire

// [tcca_props.sv]
// concurrent checks on the timer block's bus and pin-level bits
`timescale 1ns/100ps
`default_nettype none
`include "timer_defines.vh"
module tcca_props (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic [31:0] avs_readdata,
  input wire logic accum_input_pin,
  input wire logic ext_clk_pin
);
  // ==========================================
  // sequences
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire logic req = avs_read || avs_write;
  sequence rd_done(a);
    avs_read && !avs_waitrequest && avs_address == a;
  endsequence
  // pins pass two sync flops, so give them six quiet cycles
  sequence quiet(s);
    $stable(s) [*6];
  endsequence
  // ==========================================
  // assertions
  wait_first_a: assert property (req && !$past(req) |-> avs_waitrequest)
    else $error("first bus cycle without wait");
  one_wait_a: assert property (req && avs_waitrequest |=> !avs_waitrequest)
    else $error("more than one wait cycle");
  idle_wait_a: assert property (!req |-> !avs_waitrequest)
    else $error("wait raised while idle");
  read_hold_a: assert property (!avs_read |=> $stable(avs_readdata))
    else $error("read data moved without a read");
  upper_zero_a: assert property (avs_readdata[31:16] == 16'h0000)
    else $error("upper read data not zero");
  unmapped_read_a: assert property (avs_read && !avs_waitrequest &&
    (avs_address < `IDX_MASTER_ACTION || avs_address > `IDX_FLAGS ||
    avs_address[0]) |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  flag_spare_a: assert property (rd_done(`IDX_FLAGS) |->
    avs_readdata[6] == 1'b0 && avs_readdata[3:0] == 4'h0)
    else $error("spare flag bits not zero");
  pin_level_a: assert property (quiet(accum_input_pin) ##0
    rd_done(`IDX_ACCUM) |-> avs_readdata[15] == accum_input_pin)
    else $error("accumulator pin level wrong");
  clk_level_a: assert property (quiet(ext_clk_pin) ##0
    rd_done(`IDX_ACCUM) |-> avs_readdata[11] == ext_clk_pin)
    else $error("external clock level wrong");
endmodule // tcca_props
bind timer_capture_compare_accumulator tcca_props u_props (
  .clk(clk), .rst_n(rst_n), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest), .avs_readdata(avs_readdata),
  .accum_input_pin(accum_input_pin), .ext_clk_pin(ext_clk_pin));
`default_nettype wire

// [testbench.sv]
// self-checking bench for the timer block
`timescale 1ns/100ps
`default_nettype none
`include "timer_defines.vh"
module testbench;
  logic clk, rst_n, avs_read, avs_write, avs_waitrequest, timer_irq;
  logic accum_input_pin, ch5_pin_in, ext_clk_pin;
  logic [5:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic [3:1] capture_pin;
  logic [5:1] match_pin_out, match_pin_oe;
  logic [15:0] q, q2;
  int fails, cmp_count;
  typedef struct {logic [5:0] a; logic [15:0] d; logic [15:0] e;} row_t;
  // ==========================================
  // write then read back
  row_t rows [8] = '{
    '{`IDX_MASTER_ACTION, 16'hffff, 16'hf8f8},
    '{`IDX_MATCH_1, 16'h1234, 16'h1234},
    '{`IDX_MATCH_4, 16'hfedc, 16'hfedc},
    '{`IDX_CAPTURE_2, 16'h0000, 16'hffff},
    '{`IDX_ACCUM, 16'h3f42, 16'h3742},
    '{`IDX_SHARED, 16'h0000, 16'hffff},
    '{6'h01, 16'hffff, 16'h0000},
    '{`IDX_IRQ_ENABLE, 16'hff38, 16'hff38}};
  timer_capture_compare_accumulator DUT (.clk(clk), .rst_n(rst_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .capture_pin(capture_pin), .ch5_pin_in(ch5_pin_in),
    .accum_input_pin(accum_input_pin), .ext_clk_pin(ext_clk_pin),
    .match_pin_out(match_pin_out), .match_pin_oe(match_pin_oe),
    .timer_irq(timer_irq));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // ==========================================
  // tasks
  task automatic chk(input string n, input logic [15:0] e, g);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic ticks(input int k);
    repeat (k) @(posedge clk);
  endtask
  task automatic bus(input logic we, input logic [5:0] a,
    input logic [15:0] d);
    int n = 0;
    avs_address <= a;
    avs_write <= we;
    avs_read <= !we;
    avs_writedata <= {16'h0000, d};
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    q = avs_readdata[15:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (avs_waitrequest !== 1'b0) begin
      fails++;
      finish_test();
    end
    @(posedge clk);
  endtask
  task automatic wait_pin(input int i);
    int n = 0;
    while (match_pin_out[i] !== 1'b1 && n < 400) begin
      @(posedge clk);
      n++;
    end
    if (n >= 400) begin
      fails++;
      finish_test();
    end
  endtask
  task automatic do_reset();
    rst_n <= 1'b0;
    ticks(3);
    rst_n <= 1'b1;
    ticks(1);
  endtask
  // ==========================================
  // main sequence
  initial begin
    rst_n = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 6'h00;
    avs_writedata = 32'h0;
    capture_pin = 3'b000;
    accum_input_pin = 1'b0;
    ch5_pin_in = 1'b0;
    ext_clk_pin = 1'b0;
    do_reset();
    foreach (rows[i]) begin
      bus(1'b1, rows[i].a, rows[i].d);
      bus(1'b0, rows[i].a, 16'h0000);
      chk("readback", rows[i].e, q);
    end
    do_reset(); // mid-run reset
    for (int a = 8; a <= 34; a += 2) begin
      bus(1'b0, 6'(a), 16'h0000);
      q2 = (a >= 14 && a <= 28) ? 16'hffff : 16'h0000;
      if (a != 10) chk("reset", q2, q);
    end
    bus(1'b1, `IDX_IRQ_ENABLE, 16'h1000);
    bus(1'b1, `IDX_MATCH_2, 16'h0040);
    bus(1'b1, `IDX_ACTION_EDGE, 16'h0101);
    wait_pin(2);
    chk("oe", 16'h0003, {11'h0, match_pin_oe});
    bus(1'b0, `IDX_FLAGS, 16'h0000);
    chk("flags", 16'h1000, q);
    chk("irq", 16'h0001, {15'h0, timer_irq});
    bus(1'b1, `IDX_FLAGS, 16'h1000);
    bus(1'b0, `IDX_FLAGS, 16'h0000);
    chk("flags clear", 16'h0000, q);
    chk("irq off", 16'h0000, {15'h0, timer_irq});
    // master match must win over pin two's own toggle state
    bus(1'b1, `IDX_MASTER_ACTION, 16'h3020);
    bus(1'b1, `IDX_MATCH_1, 16'h0060);
    wait_pin(3);
    chk("pins", 16'h0004, {11'h0, match_pin_out});
    capture_pin <= 3'b001;
    ticks(8);
    bus(1'b0, `IDX_CAPTURE_1, 16'h0000);
    q2 = q;
    chk("capture", 16'h1, {15'h0, q > 16'h005f && q < 16'h0070});
    capture_pin <= 3'b000;
    ticks(8);
    bus(1'b0, `IDX_CAPTURE_1, 16'h0000);
    chk("no fall capture", q2, q);
    bus(1'b0, `IDX_FLAGS, 16'h0000);
    chk("capture flag", 16'h0100, q & 16'h0100);
    bus(1'b1, `IDX_FLAGS, 16'hffff);
    bus(1'b1, `IDX_ACCUM, 16'h50fe);
    repeat (2) begin
      accum_input_pin <= 1'b1;
      ticks(4);
      accum_input_pin <= 1'b0;
      ticks(4);
    end
    bus(1'b0, `IDX_ACCUM, 16'h0000);
    chk("accum", 16'h5000, q);
    bus(1'b0, `IDX_FLAGS, 16'h0000);
    chk("accum flags", 16'h0030, q & 16'h0030);
    // one rising edge counts and both pin levels read back high
    accum_input_pin <= 1'b1;
    ext_clk_pin <= 1'b1;
    ticks(6);
    bus(1'b0, `IDX_ACCUM, 16'h0000);
    chk("pin levels", 16'hd801, q);
    bus(1'b1, `IDX_ACCUM, 16'h0400);
    bus(1'b1, `IDX_ACTION_EDGE, 16'h0040);
    bus(1'b1, `IDX_FLAGS, 16'hffff);
    bus(1'b0, `IDX_COUNT, 16'h0000);
    q2 = q;
    ch5_pin_in <= 1'b1;
    ticks(8);
    bus(1'b0, `IDX_SHARED, 16'h0000);
    chk("ch5 capture", 16'h1, {15'h0, q > q2 && q - q2 < 16'h8});
    bus(1'b0, `IDX_FLAGS, 16'h0000);
    chk("ch5 flag", 16'h8000, q & 16'h8000);
    bus(1'b1, `IDX_IRQ_ENABLE, 16'h0008);
    q2 = {15'h0, match_pin_out[1]};
    ticks(2);
    chk("clock out", q2 ^ 16'h0001, {15'h0, match_pin_out[1]});
    finish_test();
  end
endmodule // testbench
`default_nettype wire
